// ---- hdl/mist_core.sv ----
// Operation
// - External pin flag sets on the edge type chosen for that pin.
// - External pin vector taken only with global and pin enables set.
// - Edge select per pin: rising, falling, both, or function off.
// - Pin acts as interrupt input only while its enable bit is set.
// - Servicing external pin clears its flag and the global enable.
// - Pull-high selection stays in force while pin used for interrupts.
// - Each of two comparator flags sets on any output change.
// - Comparator vector needs global enable and that comparator's enable.
// - Servicing comparator clears its flag and the global enable.
// - Six multi-function groups merge peripheral source requests.
// - Group flag sets when any included source raises its flag.
// - Group vector only while enabled and stack not full; else waits.
// - Servicing clears group flag and global enable; software clears sources. Here the group flag stays set while any masked source flag is high.
// - Conversion done sets flag; vector needs global and converter enables.
// - Servicing converter clears its flag and the global enable.
// - Each time base sets its flag on overflow; vector needs enables.
// - Servicing a time base clears its flag and the global enable.
// - Time base clock passes a divider chosen by control bits.
// - Control bit 7 runs or stops the one counter feeding both time bases.
// - Control bit 6 picks dedicated clock or system clock over four.
// - Bits 5:4 give time base one period 4096 to 32768 ticks.
// - Control bit 3 enables slow crystal low-power mode.
// - Flags other than external pin flags set regardless of enable; a newly set flag wakes the device.
`timescale 1ns/100ps
`default_nettype none

module mist_core #(
    parameter int TB_CNT_W = mist_pkg::TB_CNT_W
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic [3:0] ext_irq_pins_in,
    input wire logic [3:0] pin_pull_high_in,
    input wire logic [1:0] cmp_out_in,
    input wire logic conv_done_in,
    input wire logic tbase_clk_in,
    input wire logic [29:0] grp_src_flags_in,
    input wire logic [5:0] grp_src_mask_in,
    input wire logic stack_full_in,
    input wire logic irq_ack_in,
    output logic [14:0] irq_pending_out,
    output logic irq_req_out,
    output logic [3:0] irq_src_out,
    output logic wake_out,
    output logic [3:0] pin_pull_high_out,
    output logic slow_xtal_low_power_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] pin_s1;
        logic [3:0] pin_s2;
        logic [3:0] pin_s3;
        logic [1:0] cmp_s1;
        logic [1:0] cmp_s2;
        logic [1:0] cmp_s3;
        logic [2:0] done_s;
        logic [2:0] tbc_s;
        logic [7:0] tbc;
        logic [7:0] edge_select_reg;
        logic [14:0] enables;
        logic [14:0] flags;
        logic global_irq_enable;
        logic [1:0] sys_div;
        logic [TB_CNT_W-1:0] tb_cnt;
        logic [TB_CNT_W-1:0] tb_cnt_old;
        logic irq_req;
        logic [3:0] irq_src;
        logic [14:0] pending;
        logic wake;
        logic [31:0] rdata;
        logic wait_n;
        logic busy;
    } mist_state_t;

    mist_state_t st_q;
    mist_state_t st_d;

    // Index of the lowest pending set bit; low index wins
    function automatic logic [3:0] mist_first(input logic [14:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = mist_pkg::N_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    // Divider tap for a period of 2**n ticks
    function automatic logic tb_tap(input logic [TB_CNT_W-1:0] c, input int n);
        return c[n - 1];
    endfunction

    logic [3:0] pin_rise;
    logic [3:0] pin_fall;
    logic [3:0] pin_hit;
    logic [1:0] cmp_chg;
    logic tb_tick;
    logic tb0_ovf;
    logic tb1_ovf;
    logic [14:0] set_ev;
    logic [14:0] svc_clr;
    logic [14:0] sw_clr;
    logic [14:0] ready;
    logic hit;
    int p0;
    int p1;

    always_comb begin
        st_d = st_q;
        // Two-flop sync, third stage only feeds edge detection
        st_d.pin_s1 = ext_irq_pins_in;
        st_d.pin_s2 = st_q.pin_s1;
        st_d.pin_s3 = st_q.pin_s2;
        st_d.cmp_s1 = cmp_out_in;
        st_d.cmp_s2 = st_q.cmp_s1;
        st_d.cmp_s3 = st_q.cmp_s2;
        st_d.done_s = {st_q.done_s[1:0], conv_done_in};
        st_d.tbc_s = {st_q.tbc_s[1:0], tbase_clk_in};

        // ------------------------------------------------------------
        // Event detection
        // ------------------------------------------------------------
        pin_rise = st_q.pin_s2 & ~st_q.pin_s3;
        pin_fall = ~st_q.pin_s2 & st_q.pin_s3;
        for (int i = 0; i < mist_pkg::N_EXT; i++) begin
            case (st_q.edge_select_reg[2*i +: 2])
                mist_pkg::EDGE_RISE: pin_hit[i] = pin_rise[i];
                mist_pkg::EDGE_FALL: pin_hit[i] = pin_fall[i];
                mist_pkg::EDGE_BOTH: pin_hit[i] = pin_rise[i] | pin_fall[i];
                default: pin_hit[i] = 1'b0;
            endcase
        end
        // Pin only acts as interrupt input while enabled
        pin_hit = pin_hit & st_q.enables[3:0];
        cmp_chg = st_q.cmp_s2 ^ st_q.cmp_s3;

        // ------------------------------------------------------------
        // Time base
        // ------------------------------------------------------------
        st_d.sys_div = st_q.sys_div + 2'h1;
        tb_tick = st_q.tbc[mist_pkg::TBC_CKSEL_BIT] ? (st_q.sys_div == 2'(mist_pkg::SYS_DIV - 1))
                                                     : (st_q.tbc_s[1] & ~st_q.tbc_s[2]);
        st_d.tb_cnt_old = st_q.tb_cnt;
        if (!st_q.tbc[mist_pkg::TBC_RUN_BIT]) begin
            st_d.tb_cnt = '0;
        end else if (tb_tick) begin
            st_d.tb_cnt = st_q.tb_cnt + 1'b1;
        end
        p0 = mist_pkg::TB0_BASE_LOG2 + int'(st_q.tbc[mist_pkg::TBC_P0_LSB +: 3]);
        p1 = mist_pkg::TB1_BASE_LOG2 + int'(st_q.tbc[mist_pkg::TBC_P1_LSB +: 2]);
        // Overflow when the selected tap falls
        tb0_ovf = tb_tap(st_q.tb_cnt_old, p0) & ~tb_tap(st_q.tb_cnt, p0);
        tb1_ovf = tb_tap(st_q.tb_cnt_old, p1) & ~tb_tap(st_q.tb_cnt, p1);

        // ------------------------------------------------------------
        // Flags
        // ------------------------------------------------------------
        set_ev = '0;
        set_ev[3:0] = pin_hit;
        set_ev[mist_pkg::B_CMP0] = cmp_chg[0];
        set_ev[mist_pkg::B_CMP1] = cmp_chg[1];
        set_ev[mist_pkg::B_CONV] = st_q.done_s[1] & ~st_q.done_s[2];
        set_ev[mist_pkg::B_TB0] = tb0_ovf;
        set_ev[mist_pkg::B_TB1] = tb1_ovf;
        for (int g = 0; g < mist_pkg::N_GRP; g++) begin
            // Source flags remain owned by the peripherals
            set_ev[mist_pkg::B_GRP + g] = |(grp_src_flags_in[5*g +: 5]) & grp_src_mask_in[g];
        end

        ready = st_q.flags & st_q.enables;
        hit = st_q.global_irq_enable & (|ready) & ~stack_full_in;
        svc_clr = '0;
        if (irq_ack_in && st_q.irq_req) begin
            svc_clr[st_q.irq_src] = 1'b1;
        end
        sw_clr = '0;
        // Writes land in the answer cycle, when the master sees waitrequest low
        if (avs_write_in && st_q.wait_n && avs_address_in == mist_pkg::ADDR_FLAG) begin
            sw_clr = ~avs_writedata_in[14:0];
        end
        // Set wins over any clear
        st_d.flags = (st_q.flags & ~svc_clr & ~sw_clr) | set_ev;
        st_d.wake = |(set_ev & ~st_q.flags);

        st_d.irq_req = hit & ~(irq_ack_in & st_q.irq_req);
        st_d.irq_src = mist_first(ready);
        st_d.pending = ready;
        if (irq_ack_in && st_q.irq_req) begin
            st_d.global_irq_enable = 1'b0;
        end

        // ------------------------------------------------------------
        // Avalon slave: one wait cycle, then answer
        // ------------------------------------------------------------
        st_d.wait_n = (avs_read_in | avs_write_in) & ~st_q.wait_n;
        st_d.busy = ~st_d.wait_n;
        st_d.rdata = '0;
        if (avs_write_in && st_q.wait_n) begin
            case (avs_address_in)
                mist_pkg::ADDR_TBC: st_d.tbc = avs_writedata_in[7:0];
                mist_pkg::ADDR_EDGE: st_d.edge_select_reg = avs_writedata_in[7:0];
                mist_pkg::ADDR_ENA: st_d.enables = avs_writedata_in[14:0];
                mist_pkg::ADDR_CTRL: begin
                    if (!(irq_ack_in && st_q.irq_req)) begin
                        st_d.global_irq_enable = avs_writedata_in[mist_pkg::CTRL_GIE_BIT];
                    end
                end
                default: st_d.tbc = st_d.tbc;
            endcase
        end
        if (avs_read_in && !st_q.wait_n) begin
            case (avs_address_in)
                mist_pkg::ADDR_TBC: st_d.rdata = {24'h0, st_q.tbc};
                mist_pkg::ADDR_EDGE: st_d.rdata = {24'h0, st_q.edge_select_reg};
                mist_pkg::ADDR_ENA: st_d.rdata = {17'h0, st_q.enables};
                mist_pkg::ADDR_FLAG: st_d.rdata = {17'h0, st_q.flags};
                mist_pkg::ADDR_GRP: st_d.rdata = {26'h0, st_q.flags[mist_pkg::B_GRP +: 6]};
                mist_pkg::ADDR_CTRL: st_d.rdata = {29'h0, st_q.tbc[mist_pkg::TBC_LP_BIT],
                                                   stack_full_in, st_q.global_irq_enable};
                default: st_d.rdata = '0;
            endcase
        end

        if (sys_rst_in) begin
            st_d = '0;
            st_d.busy = 1'b1;
            st_d.tbc = mist_pkg::TBC_RESET;
        end
    end

    always_ff @(posedge clk_in) begin
        st_q <= st_d;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic [3:0] pull_q;
    logic lp_q;
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            pull_q <= 4'h0;
            lp_q <= 1'b0;
        end else begin
            // Pull-ups pass through regardless of interrupt use
            pull_q <= pin_pull_high_in;
            lp_q <= st_q.tbc[mist_pkg::TBC_LP_BIT];
        end
    end

    assign avs_readdata_out = st_q.rdata;
    assign avs_waitrequest_out = st_q.busy;
    assign irq_pending_out = st_q.pending;
    assign irq_req_out = st_q.irq_req;
    assign irq_src_out = st_q.irq_src;
    assign wake_out = st_q.wake;
    assign pin_pull_high_out = pull_q;
    assign slow_xtal_low_power_out = lp_q;

endmodule

`default_nettype wire

// ---- hdl/mist_pkg.sv ----
package mist_pkg;

    // ------------------------------------------------------------
    // Register map (word aligned byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_TBC = 8'h00;
    localparam logic [7:0] ADDR_EDGE = 8'h04;
    localparam logic [7:0] ADDR_ENA = 8'h08;
    localparam logic [7:0] ADDR_FLAG = 8'h0c;
    localparam logic [7:0] ADDR_GRP = 8'h10;
    localparam logic [7:0] ADDR_CTRL = 8'h14;

    // ------------------------------------------------------------
    // Time base control fields
    // ------------------------------------------------------------
    localparam logic [7:0] TBC_RESET = 8'h37;
    localparam int TBC_RUN_BIT = 7;
    localparam int TBC_CKSEL_BIT = 6;
    localparam int TBC_P1_LSB = 4;
    localparam int TBC_LP_BIT = 3;
    localparam int TBC_P0_LSB = 0;
    localparam int TB1_BASE_LOG2 = 12;
    localparam int TB0_BASE_LOG2 = 8;
    localparam int SYS_DIV = 4;
    localparam int TB_CNT_W = 16;

    // ------------------------------------------------------------
    // Edge select codes, two bits per pin
    // ------------------------------------------------------------
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // ------------------------------------------------------------
    // Flag / enable bit positions
    // ------------------------------------------------------------
    localparam int N_EXT = 4;
    localparam int N_GRP = 6;
    localparam int B_CMP0 = 4;
    localparam int B_CMP1 = 5;
    localparam int B_CONV = 6;
    localparam int B_TB0 = 7;
    localparam int B_TB1 = 8;
    localparam int B_GRP = 9;
    localparam int N_SRC = 15;
    localparam int CTRL_GIE_BIT = 0;
    localparam int CTRL_SFULL_BIT = 1;
    localparam int CTRL_LP_BIT = 2;

endpackage

// ---- sim/mist_core_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module mist_core_asserts (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic [3:0] pin_pull_high_in,
    input wire logic stack_full_in,
    input wire logic irq_ack_in,
    input wire logic [14:0] irq_pending_out,
    input wire logic irq_req_out,
    input wire logic [3:0] irq_src_out,
    input wire logic [3:0] pin_pull_high_out,
    input wire logic slow_xtal_low_power_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_req; (avs_read_in || avs_write_in) && avs_waitrequest_out; endsequence
    sequence s_done; (avs_read_in || avs_write_in) && !avs_waitrequest_out; endsequence
    property p_wait; s_req |=> !avs_waitrequest_out; endproperty
    property p_stand; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
    property p_unmap;
        s_done ##0 (avs_read_in && avs_address_in > 8'h14) |-> avs_readdata_out == 32'h0;
    endproperty
    // Output may lag the register by one flop, so look two cycles on
    property p_lp;
        s_done ##0 (avs_write_in && avs_address_in == 8'h00)
            |-> ##2 slow_xtal_low_power_out == $past(avs_writedata_in[3], 2);
    endproperty
    property p_pull;
        !$past(sys_rst_in) |-> pin_pull_high_out == $past(pin_pull_high_in);
    endproperty
    property p_ack; irq_ack_in && irq_req_out |-> ##2 !irq_req_out [*2]; endproperty
    property p_stack; stack_full_in |=> !irq_req_out; endproperty
    property p_src;
        irq_req_out && $stable(irq_pending_out) |-> irq_pending_out[irq_src_out]
            && (irq_pending_out & ((15'h1 << irq_src_out) - 15'h1)) == 15'h0;
    endproperty
    a_wait: assert property (p_wait) else $error("no answer after one wait state");
    a_stand: assert property (p_stand) else $error("answer held too long");
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    a_lp: assert property (p_lp) else $error("low power output wrong");
    a_pull: assert property (p_pull) else $error("pull-high not passed");
    a_ack: assert property (p_ack) else $error("request after service");
    a_stack: assert property (p_stack) else $error("request with stack full");
    a_src: assert property (p_src) else $error("bad vector index");
endmodule
`default_nettype wire

// ---- sim/mist_cpu_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Core side: vector fetch and stack
// ----------------------------------------
module mist_cpu_model #(
    parameter int DEPTH = 1
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic irq_req_in,
    input wire logic ret_in,
    input wire logic [3:0] lat_in,
    output logic irq_ack_out,
    output logic stack_full_out
);
    logic [3:0] wait_q;
    logic hold_q;
    int depth_q;
    assign stack_full_out = depth_q >= DEPTH;
    always_ff @(posedge clk_in) begin
        irq_ack_out <= 1'b0;
        if (sys_rst_in) begin
            wait_q <= 4'h0;
            hold_q <= 1'b0;
            depth_q <= 0;
        end else begin
            // Request lags the ack; hold off so one call is not taken twice
            if (!irq_req_in) begin
                hold_q <= 1'b0;
            end
            if (irq_req_in && !hold_q) begin
                wait_q <= wait_q + 4'h1;
                if (wait_q >= lat_in) begin
                    irq_ack_out <= 1'b1;
                    hold_q <= 1'b1;
                    wait_q <= 4'h0;
                end
            end
            depth_q <= depth_q + int'(irq_ack_out) - int'(ret_in && depth_q > 0);
        end
    end
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
    typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} mist_row_t;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [7:0] addr = 8'h0;
    logic rd = 1'b0, wr = 1'b0, conv = 1'b0, tbase_clk_sel = 1'b0, ret = 1'b0;
    logic [31:0] wd = 32'h0, rdo, rdata;
    logic wait_o, req, wake, ack, sfull;
    logic [3:0] pins = 4'h0, pull = 4'h5, lat = 4'h0;
    logic [1:0] cmp = 2'h0;
    logic [29:0] gsrc = 30'h0;
    logic [5:0] gmask = 6'h0;
    int num_errors = 0, checks_done = 0, wakes = 0;
    mist_row_t rows[6] = '{
        '{mist_pkg::ADDR_TBC, 1'b0, 32'h0, 32'h37},
        '{mist_pkg::ADDR_TBC, 1'b1, 32'h2d, 32'h2d},
        '{mist_pkg::ADDR_EDGE, 1'b1, 32'he4, 32'he4},
        '{mist_pkg::ADDR_ENA, 1'b1, 32'h7fff, 32'h7fff},
        '{mist_pkg::ADDR_GRP, 1'b1, 32'h3f, 32'h0},
        '{8'h20, 1'b1, 32'hff, 32'h0}};

    always #4 clk_in = ~clk_in;
    always @(posedge clk_in) tbase_clk_sel <= ~tbase_clk_sel;
    always @(posedge clk_in) if (wake === 1'b1) wakes <= wakes + 1;

    mist_core #(.TB_CNT_W(16)) i_mist_core (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_readdata_out(rdo), .avs_waitrequest_out(wait_o), .ext_irq_pins_in(pins),
        .pin_pull_high_in(pull), .cmp_out_in(cmp), .conv_done_in(conv),
        .tbase_clk_in(tbase_clk_sel), .grp_src_flags_in(gsrc), .grp_src_mask_in(gmask),
        .stack_full_in(sfull), .irq_ack_in(ack), .irq_pending_out(),
        .irq_req_out(req), .irq_src_out(), .wake_out(wake),
        .pin_pull_high_out(), .slow_xtal_low_power_out());
    mist_cpu_model i_mist_cpu_model (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .irq_req_in(req), .ret_in(ret), .lat_in(lat), .irq_ack_out(ack),
        .stack_full_out(sfull));

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_in);
        addr <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        do @(posedge clk_in); while (wait_o !== 1'b0);
        rdata = rdo;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        chk(rdata, e);
    endtask
    // One return from the core, then re-enable and let it take the next call
    task serve(input logic [31:0] e);
        ret <= 1'b1;
        @(posedge clk_in);
        ret <= 1'b0;
        bus(mist_pkg::ADDR_CTRL, 1'b1, 32'h1);
        repeat (12) @(posedge clk_in);
        rdchk(mist_pkg::ADDR_FLAG, e);
    endtask
    task stop_test;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (40000) @(posedge clk_in);
        num_errors++;
        stop_test();
    end
    initial begin
        repeat (10) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].w) bus(rows[i].a, 1'b1, rows[i].d);
            rdchk(rows[i].a, rows[i].e);
        end
        bus(mist_pkg::ADDR_FLAG, 1'b1, 32'h0);
        pins <= 4'hf;
        cmp <= 2'h3;
        conv <= 1'b1;
        pull <= 4'ha;
        repeat (8) @(posedge clk_in);
        rdchk(mist_pkg::ADDR_FLAG, 32'h7a);
        bus(mist_pkg::ADDR_FLAG, 1'b1, 32'h0);
        pins <= 4'h0;
        cmp <= 2'h0;
        conv <= 1'b0;
        repeat (8) @(posedge clk_in);
        rdchk(mist_pkg::ADDR_FLAG, 32'h3c);
        chk(32'(wakes > 1), 32'h1);
        gmask <= 6'h3e;
        gsrc <= 30'h2000_0001;
        repeat (4) @(posedge clk_in);
        rdchk(mist_pkg::ADDR_GRP, 32'h20);
        serve(32'h4038);
        rdchk(mist_pkg::ADDR_CTRL, 32'h6);
        bus(mist_pkg::ADDR_CTRL, 1'b1, 32'h1);
        repeat (8) @(posedge clk_in);
        chk({31'h0, req}, 32'h0);
        lat <= 4'h6;
        serve(32'h4030);
        serve(32'h4020);
        serve(32'h4000);
        serve(32'h4000);
        rdchk(mist_pkg::ADDR_CTRL, 32'h6);
        gsrc <= 30'h0;
        bus(mist_pkg::ADDR_FLAG, 1'b1, 32'h0);
        rdchk(mist_pkg::ADDR_FLAG, 32'h0);
        bus(mist_pkg::ADDR_TBC, 1'b1, 32'hc0);
        bus(mist_pkg::ADDR_FLAG, 1'b1, 32'h0);
        repeat (990) @(posedge clk_in);
        rdchk(mist_pkg::ADDR_FLAG, 32'h0);
        repeat (60) @(posedge clk_in);
        rdchk(mist_pkg::ADDR_FLAG, 32'h80);
        serve(32'h0);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rdchk(mist_pkg::ADDR_TBC, 32'h37);
        stop_test();
    end
endmodule
bind mist_core mist_core_asserts i_mist_core_asserts (.*);
`default_nettype wire
